// File: hdl/uart_fifo_control_dma_ready.sv
// fifo control, trigger levels and dma request pins for two channels
// assumes host strobes and uart core signals are on sys_clk
`timescale 1ns/100ps
module uart_fifo_control_dma_ready #(
	parameter int DEPTH = uart_fifo_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// fifo control register write, channel 0 is A
	input wire logic ctlWrite,
	input wire logic ctlChannel,
	input wire logic [7:0] ctlData,
	// extended level registers, per channel
	input wire logic [1:0][7:0] extRxLevel,
	input wire logic [1:0][7:0] extTxLevel,
	input wire logic [1:0][7:0] flowThresholdLow,
	input wire logic [1:0][7:0] flowThresholdHigh,
	// host side of the transmit holding register
	input wire logic [1:0] txWrite,
	input wire logic [1:0][7:0] txWriteData,
	// transmitter unloading the transmit fifo
	input wire logic [1:0] txTake,
	output logic [1:0][7:0] txTakeData,
	// receiver loading the receive fifo
	input wire logic [1:0] rxLoad,
	input wire logic [1:0][7:0] rxLoadData,
	input wire logic [1:0] rxTimeout,
	// host side of the receive holding register
	input wire logic [1:0] rxRead,
	output logic [1:0][7:0] rxReadData,
	// status towards the rest of the uart
	output logic [1:0][7:0] fifoControl,
	output logic [1:0][7:0] txLevel,
	output logic [1:0][7:0] rxLevel,
	output logic [1:0] rxReadyIrq,
	output logic [1:0] txEmptyIrq,
	output logic [1:0] flowTrigger,
	output logic [1:0] rxOverrun,
	// dma request pins, active low
	output logic txDmaRequestNChA,
	output logic txDmaRequestNChB,
	output logic rxDmaRequestNChA,
	output logic rxDmaRequestNChB
);
	// ==========================================
	// per-channel request wires
	logic [1:0] txReqN;
	logic [1:0] rxReqN;

	assign txDmaRequestNChA = txReqN[0];
	assign txDmaRequestNChB = txReqN[1];
	assign rxDmaRequestNChA = rxReqN[0];
	assign rxDmaRequestNChB = rxReqN[1];

	// ==========================================
	// one independent slice per channel [RULE_21]
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan

		fifo_link_if #(.DATA_W(8), .CNT_W(8)) txLink ();
		fifo_link_if #(.DATA_W(8), .CNT_W(8)) rxLink ();

		logic [7:0] ctl;
		logic [7:0] rxTrigger;
		logic [7:0] txTrigger;
		logic txReqActive;
		logic rxReqActive;
		logic next_txReqActive;
		logic next_rxReqActive;
		logic txReqOut;
		logic rxReqOut;
		logic rxIrq;
		logic txIrq;
		logic flow;
		logic overrun;
		logic [7:0] txData;
		logic [7:0] rxData;
		uart_fifo_pkg::dma_mode_t dmaMode;

		// ==========================================
		// control register write decode
		wire ctlHit = ctlWrite && (ctlChannel == 1'(ch));
		wire fifoOn = ctl[uart_fifo_pkg::FIFO_EN_BIT];
		wire newFifoOn = ctlData[uart_fifo_pkg::FIFO_EN_BIT];
		// toggling the enable also empties both fifos, so stale
		// bytes never straddle a capacity change
		wire enableFlip = ctlHit && (newFifoOn != fifoOn);
		wire txFlush = (ctlHit && ctlData[uart_fifo_pkg::TX_FLUSH_BIT])
			|| enableFlip; // [RULE_11]
		wire rxFlush = (ctlHit && ctlData[uart_fifo_pkg::RX_FLUSH_BIT])
			|| enableFlip; // [RULE_12]
		wire modeBit = ctl[uart_fifo_pkg::DMA_MODE_BIT];

		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				ctl <= uart_fifo_pkg::CTL_RESET; // [RULE_10] [RULE_13]
			end else if (ctlHit) begin
				// flush bits are never stored, so they read back zero
				ctl <= ctlData & uart_fifo_pkg::CTL_STORED_MASK;
			end
		end

		// mode 1 only makes sense with the fifos on [RULE_10]
		assign dmaMode = (modeBit && fifoOn) ? uart_fifo_pkg::DMA_MODE1
			: uart_fifo_pkg::DMA_MODE0;

		// ==========================================
		// trigger levels
		uart_trigger_decode u_trig (
			.fifoControl(ctl),
			.extRxLevel(extRxLevel[ch]),
			.extTxLevel(extTxLevel[ch]),
			.flowThresholdLow(flowThresholdLow[ch]),
			.flowThresholdHigh(flowThresholdHigh[ch]),
			.rxTrigger(rxTrigger),
			.txTrigger(txTrigger)
		);

		// ==========================================
		// character fifos; disabled means a one-byte holding reg
		wire [7:0] capacity = fifoOn ? 8'(DEPTH)
			: uart_fifo_pkg::HOLDING_DEPTH; // [RULE_13]

		assign txLink.push = txWrite[ch];
		assign txLink.pushData = txWriteData[ch];
		assign txLink.pop = txTake[ch];
		assign txLink.flush = txFlush;
		assign txLink.limit = capacity;
		assign txData = txLink.popData;

		assign rxLink.push = rxLoad[ch];
		assign rxLink.pushData = rxLoadData[ch];
		assign rxLink.pop = rxRead[ch];
		assign rxLink.flush = rxFlush;
		assign rxLink.limit = capacity;
		assign rxData = rxLink.popData;

		uart_char_fifo #(.DEPTH(DEPTH), .DATA_W(8)) u_txFifo (
			.sys_clk(sys_clk),
			.rst(rst),
			.link(txLink.fifo)
		);

		uart_char_fifo #(.DEPTH(DEPTH), .DATA_W(8)) u_rxFifo (
			.sys_clk(sys_clk),
			.rst(rst),
			.link(rxLink.fifo)
		);

		// ==========================================
		// level comparisons
		wire txBelow = txLink.count < txTrigger;
		wire rxAtTrig = rxLink.count >= rxTrigger;
		wire rxHasData = !rxLink.empty;

		// ==========================================
		// transmit request state
		always_comb begin
			next_txReqActive = txReqActive;
			case (dmaMode)
				uart_fifo_pkg::DMA_MODE0: begin
					// empty asks, first written character releases
					next_txReqActive = txLink.empty; // [RULE_01] [RULE_02]
				end
				uart_fifo_pkg::DMA_MODE1: begin
					if (txLink.full) begin
						next_txReqActive = 1'b0; // [RULE_06]
					end else if (txBelow) begin
						next_txReqActive = 1'b1; // [RULE_05]
					end
				end
				default: begin
					next_txReqActive = 1'b0;
				end
			endcase
		end

		// ==========================================
		// receive request state
		always_comb begin
			next_rxReqActive = rxReqActive;
			case (dmaMode)
				uart_fifo_pkg::DMA_MODE0: begin
					// any waiting character asks [RULE_03] [RULE_04]
					next_rxReqActive = rxHasData;
				end
				uart_fifo_pkg::DMA_MODE1: begin
					if (!rxHasData) begin
						next_rxReqActive = 1'b0; // [RULE_08]
					end else if (rxAtTrig || rxTimeout[ch]) begin
						next_rxReqActive = 1'b1; // [RULE_07]
					end
				end
				default: begin
					next_rxReqActive = 1'b0;
				end
			endcase
		end

		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				txReqActive <= 1'b0;
				rxReqActive <= 1'b0;
			end else begin
				txReqActive <= next_txReqActive;
				rxReqActive <= next_rxReqActive;
			end
		end

		// pins are registered copies so they never glitch
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				txReqOut <= 1'b1;
				rxReqOut <= 1'b1;
			end else begin
				txReqOut <= !next_txReqActive;
				rxReqOut <= !next_rxReqActive;
			end
		end

		assign txReqN[ch] = txReqOut;
		assign rxReqN[ch] = rxReqOut;

		// ==========================================
		// interrupt and flow levels
		// non-fifo mode: irqs fall back to holding register full/empty, flow stays low
		wire rxIrqNext = fifoOn ? rxAtTrig : rxHasData; // [RULE_16] [RULE_19]
		wire txIrqNext = fifoOn ? txBelow : txLink.empty; // [RULE_17]
		wire flowNext = fifoOn && rxAtTrig; // [RULE_16]
		// a byte offered to a full receive fifo is dropped
		wire overrunNext = rxLoad[ch] && rxLink.full && !rxFlush;

		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				rxIrq <= 1'b0;
				txIrq <= 1'b0;
				flow <= 1'b0;
				overrun <= 1'b0;
			end else begin
				rxIrq <= rxIrqNext;
				txIrq <= txIrqNext;
				flow <= flowNext;
				overrun <= overrunNext;
			end
		end

		// ==========================================
		// outputs of this channel
		assign fifoControl[ch] = ctl;
		assign txLevel[ch] = txLink.count;
		assign rxLevel[ch] = rxLink.count;
		assign txTakeData[ch] = txData;
		assign rxReadData[ch] = rxData;
		assign rxReadyIrq[ch] = rxIrq;
		assign txEmptyIrq[ch] = txIrq;
		assign flowTrigger[ch] = flow;
		assign rxOverrun[ch] = overrun;
	end

endmodule

// File: hdl/uart_fifo_pkg.sv
// constants shared by the dual-channel fifo control and dma request block
// assumes one clock domain, host writes on the same clock as the fifos
//
// Overview of operation
// RULE_01 - mode 0: tx request low while tx fifo, or holding reg, empty
// RULE_02 - mode 0: tx request returns high when first character is written
// RULE_03 - mode 0 or no fifo: rx request low while a character waits
// RULE_04 - mode 0: rx request returns high only once no character remains
// RULE_05 - mode 1 with fifo: tx request low when fill below tx trigger
// RULE_06 - mode 1: tx request high when tx fifo completely full
// RULE_07 - mode 1 with fifo: rx request low at rx trigger or time-out
// RULE_08 - mode 1: rx request stays low until rx fifo fully emptied
// RULE_09 - rx fifo keeps accepting characters past trigger until full
// RULE_10 - dma mode bit: clear selects mode 0, set mode 1, resets to 0
// RULE_11 - tx flush bit discards tx fifo and counters, then reads zero
// RULE_12 - rx flush bit discards rx fifo and counters, then reads zero
// RULE_13 - fifo enable bit enables both fifos; disabled after reset
// RULE_14 - rx trigger codes 00..11 select 8, 16, 24, 28 bytes
// RULE_15 - tx trigger codes 00..11 select 16, 8, 24, 30 bytes
// RULE_16 - rx ready interrupt and flow signal when rx count reaches trigger
// RULE_17 - tx empty interrupt when tx count falls below tx trigger
// RULE_18 - any nonzero extended level register selects extended levels
// RULE_19 - rx ready interrupt clears once rx count drops below trigger
// RULE_20 - dma controller moves data only while its request is low
// RULE_21 - each channel has own control register, fifos and requests
package uart_fifo_pkg;

	// ==========================================
	// fifo control register layout
	localparam int FIFO_EN_BIT = 0;
	localparam int RX_FLUSH_BIT = 1;
	localparam int TX_FLUSH_BIT = 2;
	localparam int DMA_MODE_BIT = 3;
	localparam int TX_TRIG_LSB = 4;
	localparam int RX_TRIG_LSB = 6;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] CTL_STORED_MASK = 8'hF9;

	// ==========================================
	// sizes and trigger levels
	localparam int FIFO_DEPTH = 32;
	localparam int LEVEL_W = 8;
	localparam logic [7:0] HOLDING_DEPTH = 8'h01;
	localparam logic [7:0] EXT_LEVEL_OFF = 8'h00;
	localparam logic [7:0] RX_TRIG_0 = 8'h08;
	localparam logic [7:0] RX_TRIG_1 = 8'h10;
	localparam logic [7:0] RX_TRIG_2 = 8'h18;
	localparam logic [7:0] RX_TRIG_3 = 8'h1C;
	localparam logic [7:0] TX_TRIG_0 = 8'h10;
	localparam logic [7:0] TX_TRIG_1 = 8'h08;
	localparam logic [7:0] TX_TRIG_2 = 8'h18;
	localparam logic [7:0] TX_TRIG_3 = 8'h1E;

	typedef enum logic {
		DMA_MODE0 = 1'b0,
		DMA_MODE1 = 1'b1
	} dma_mode_t;

endpackage

// File: hdl/fifo_link_if.sv
// signals between the control logic and one character fifo
// assumes the fifo and its user share sys_clk
`timescale 1ns/100ps
interface fifo_link_if #(
	parameter int DATA_W = 8,
	parameter int CNT_W = 8
);
	logic push;
	logic [DATA_W-1:0] pushData;
	logic pop;
	logic [DATA_W-1:0] popData;
	logic flush;
	logic [CNT_W-1:0] limit;
	logic [CNT_W-1:0] count;
	logic full;
	logic empty;

	modport fifo (
		input push, pushData, pop, flush, limit,
		output popData, count, full, empty
	);
	modport user (
		output push, pushData, pop, flush, limit,
		input popData, count, full, empty
	);
endinterface

// File: hdl/uart_char_fifo.sv
// character fifo in flip-flops with a run-time capacity limit
// assumes limit never exceeds DEPTH; flush wins over push and pop
`timescale 1ns/100ps
module uart_char_fifo #(
	parameter int DEPTH = uart_fifo_pkg::FIFO_DEPTH,
	parameter int DATA_W = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// link to the control logic
	fifo_link_if.fifo link
);
	localparam int IDX_W = $clog2(DEPTH);
	localparam logic [IDX_W-1:0] LAST = IDX_W'(DEPTH - 1);

	function automatic logic [IDX_W-1:0] bump(input logic [IDX_W-1:0] i);
		bump = (i == LAST) ? '0 : i + 1'b1;
	endfunction

	logic [DATA_W-1:0] store [DEPTH];
	logic [IDX_W-1:0] wrIdx;
	logic [IDX_W-1:0] rdIdx;
	logic [7:0] count;

	// characters past the trigger are still taken until full [RULE_09]
	wire doPush = link.push && !link.full;
	wire doPop = link.pop && !link.empty;

	assign link.count = count;
	assign link.full = (count >= link.limit);
	assign link.empty = (count == 8'h00);
	assign link.popData = store[rdIdx];

	always_ff @(posedge sys_clk) begin
		if (doPush && !link.flush) begin
			store[wrIdx] <= link.pushData;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wrIdx <= '0;
			rdIdx <= '0;
			count <= 8'h00;
		end else if (link.flush) begin
			wrIdx <= '0;
			rdIdx <= '0;
			count <= 8'h00;
		end else begin
			if (doPush) begin
				wrIdx <= bump(wrIdx);
			end
			if (doPop) begin
				rdIdx <= bump(rdIdx);
			end
			count <= count + {7'h00, doPush} - {7'h00, doPop};
		end
	end
endmodule

// File: hdl/uart_trigger_decode.sv
// trigger level selection from the control fields or extended levels
// assumes extended level registers live outside and are steady
`timescale 1ns/100ps
module uart_trigger_decode (
	// control register and extended levels
	input wire logic [7:0] fifoControl,
	input wire logic [7:0] extRxLevel,
	input wire logic [7:0] extTxLevel,
	input wire logic [7:0] flowThresholdLow,
	input wire logic [7:0] flowThresholdHigh,
	// selected levels
	output logic [7:0] rxTrigger,
	output logic [7:0] txTrigger
);
	function automatic logic [7:0] rxDecode(input logic [1:0] code);
		case (code)
			2'h0: rxDecode = uart_fifo_pkg::RX_TRIG_0;
			2'h1: rxDecode = uart_fifo_pkg::RX_TRIG_1;
			2'h2: rxDecode = uart_fifo_pkg::RX_TRIG_2;
			default: rxDecode = uart_fifo_pkg::RX_TRIG_3;
		endcase
	endfunction

	function automatic logic [7:0] txDecode(input logic [1:0] code);
		case (code)
			2'h0: txDecode = uart_fifo_pkg::TX_TRIG_0;
			2'h1: txDecode = uart_fifo_pkg::TX_TRIG_1;
			2'h2: txDecode = uart_fifo_pkg::TX_TRIG_2;
			default: txDecode = uart_fifo_pkg::TX_TRIG_3;
		endcase
	endfunction

	wire [1:0] rxCode = fifoControl[uart_fifo_pkg::RX_TRIG_LSB +: 2];
	wire [1:0] txCode = fifoControl[uart_fifo_pkg::TX_TRIG_LSB +: 2];
	// any nonzero extended register hands levels over [RULE_18]
	wire useExt = (extRxLevel != uart_fifo_pkg::EXT_LEVEL_OFF)
		|| (extTxLevel != uart_fifo_pkg::EXT_LEVEL_OFF)
		|| (flowThresholdLow != uart_fifo_pkg::EXT_LEVEL_OFF)
		|| (flowThresholdHigh != uart_fifo_pkg::EXT_LEVEL_OFF);

	assign rxTrigger = useExt ? extRxLevel : rxDecode(rxCode); // [RULE_14]
	assign txTrigger = useExt ? extTxLevel : txDecode(txCode); // [RULE_15]
endmodule

// File: tb/uart_fifo_dma_chk.sv
// checker on channel a request pins, irqs and control register
// assumes it is bound into the top module and sees its ports only
`timescale 1ns/100ps
module uart_fifo_dma_chk #(
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// control write
	input wire logic ctlWrite,
	input wire logic ctlChannel,
	input wire logic [7:0] ctlData,
	// extended levels
	input wire logic [1:0][7:0] extRxLevel,
	input wire logic [1:0][7:0] extTxLevel,
	input wire logic [1:0][7:0] flowThresholdLow,
	input wire logic [1:0][7:0] flowThresholdHigh,
	// status
	input wire logic [1:0][7:0] fifoControl,
	input wire logic [1:0][7:0] txLevel,
	input wire logic [1:0][7:0] rxLevel,
	input wire logic [1:0] rxReadyIrq,
	input wire logic [1:0] txEmptyIrq,
	// request pins
	input wire logic txDmaRequestNChA,
	input wire logic rxDmaRequestNChA
);
	localparam logic [3:0][7:0] RX_TAB = {8'h1C, 8'h18, 8'h10, 8'h08};
	localparam logic [3:0][7:0] TX_TAB = {8'h1E, 8'h18, 8'h08, 8'h10};
	logic extOn;
	logic fifoOn;
	logic m1;
	logic [7:0] rxTrig;
	logic [7:0] txTrig;
	assign extOn = |{extRxLevel[0], extTxLevel[0], flowThresholdLow[0],
		flowThresholdHigh[0]};
	assign fifoOn = fifoControl[0][0];
	assign m1 = fifoControl[0][3] & fifoOn;
	assign rxTrig = extOn ? extRxLevel[0] : RX_TAB[fifoControl[0][7:6]];
	assign txTrig = extOn ? extTxLevel[0] : TX_TAB[fifoControl[0][5:4]];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ====
	// control register
	sequence s_wr_a;
		ctlWrite && !ctlChannel;
	endsequence
	property p_ctl_store;
		s_wr_a |=> fifoControl[0] == ($past(ctlData) & 8'hF9);
	endproperty
	a_ctl_store: assert property (p_ctl_store)
		else $error("control register readback wrong");
	property p_flush_tx;
		s_wr_a ##0 ctlData[2] |=> txLevel[0] == 8'h00;
	endproperty
	a_flush_tx: assert property (p_flush_tx)
		else $error("tx fifo not flushed");
	property p_flush_rx;
		s_wr_a ##0 ctlData[1] |=> rxLevel[0] == 8'h00;
	endproperty
	a_flush_rx: assert property (p_flush_rx)
		else $error("rx fifo not flushed");
	// ====
	// request pins
	property p_tx_m0;
		!$past(rst) && $past(!m1)
		|-> txDmaRequestNChA == ($past(txLevel[0]) != 8'h00);
	endproperty
	a_tx_m0: assert property (p_tx_m0)
		else $error("mode 0 tx request wrong");
	property p_rx_m0;
		!$past(rst) && $past(!m1)
		|-> rxDmaRequestNChA == ($past(rxLevel[0]) == 8'h00);
	endproperty
	a_rx_m0: assert property (p_rx_m0)
		else $error("mode 0 rx request wrong");
	property p_tx_m1_full;
		$past(m1 && txLevel[0] == DEPTH) |-> txDmaRequestNChA;
	endproperty
	a_tx_m1_full: assert property (p_tx_m1_full)
		else $error("tx request active while full");
	property p_tx_m1_low;
		$past(m1 && txLevel[0] < txTrig) |-> !txDmaRequestNChA;
	endproperty
	a_tx_m1_low: assert property (p_tx_m1_low)
		else $error("tx request idle below trigger");
	property p_rx_m1_trig;
		$past(m1 && rxLevel[0] >= rxTrig && rxLevel[0] != 8'h00)
		|-> !rxDmaRequestNChA;
	endproperty
	a_rx_m1_trig: assert property (p_rx_m1_trig)
		else $error("rx request idle at trigger");
	property p_rx_m1_hold;
		$past(m1 && !rxDmaRequestNChA && rxLevel[0] != 8'h00)
		|-> !rxDmaRequestNChA;
	endproperty
	a_rx_m1_hold: assert property (p_rx_m1_hold)
		else $error("rx request dropped before empty");
	// ====
	// interrupt levels
	property p_rx_irq;
		!$past(rst) && $past(fifoOn)
		|-> rxReadyIrq[0] == $past(rxLevel[0] >= rxTrig);
	endproperty
	a_rx_irq: assert property (p_rx_irq)
		else $error("rx ready irq wrong");
	property p_tx_irq;
		!$past(rst) && $past(fifoOn)
		|-> txEmptyIrq[0] == $past(txLevel[0] < txTrig);
	endproperty
	a_tx_irq: assert property (p_tx_irq)
		else $error("tx empty irq wrong");
endmodule
bind uart_fifo_control_dma_ready uart_fifo_dma_chk #(.DEPTH(DEPTH))
	uart_fifo_dma_chk_inst (.sys_clk(sys_clk), .rst(rst),
	.ctlWrite(ctlWrite), .ctlChannel(ctlChannel), .ctlData(ctlData),
	.extRxLevel(extRxLevel), .extTxLevel(extTxLevel),
	.flowThresholdLow(flowThresholdLow),
	.flowThresholdHigh(flowThresholdHigh), .fifoControl(fifoControl),
	.txLevel(txLevel), .rxLevel(rxLevel), .rxReadyIrq(rxReadyIrq),
	.txEmptyIrq(txEmptyIrq), .txDmaRequestNChA(txDmaRequestNChA),
	.rxDmaRequestNChA(rxDmaRequestNChA));

// File: tb/dma_ctrl_model.sv
// dma controller model moving one character per active request
// assumes active low requests that lag the fifo counts by one cycle
`timescale 1ns/100ps
module dma_ctrl_model #(
	parameter int GAP = 3
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// enable and request pins
	input wire logic active,
	input wire logic txReqN,
	input wire logic rxReqN,
	// transfer strobes
	output logic txPush,
	output logic rxPop,
	output logic [7:0] txData
);
	int gap;
	// gap outlasts the pin lag, else one request gives a surplus move
	always @(negedge sys_clk or posedge rst) begin
		if (rst) begin
			txPush <= 1'b0;
			rxPop <= 1'b0;
			txData <= 8'h00;
			gap <= 0;
		end else begin
			txPush <= 1'b0;
			rxPop <= 1'b0;
			if (gap != 0) begin
				gap <= gap - 1;
			end else if (active && !txReqN) begin
				txPush <= 1'b1;
				txData <= txData + 8'h01;
				gap <= GAP;
			end else if (active && !rxReqN) begin
				rxPop <= 1'b1;
				gap <= GAP;
			end
		end
	end
endmodule

// File: tb/testbench.sv
// bench for the fifo control and dma request block
// assumes the dma model serves channel a, tasks drive the host side
`timescale 1ns/100ps
module testbench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ctlWrite = 1'b0;
	logic ctlChannel = 1'b0;
	logic [7:0] ctlData = 8'h00;
	logic [1:0][7:0] extRx = '0;
	logic [1:0][7:0] flowLo = '0;
	logic [1:0][7:0] zero8 = '0;
	logic [4:0] act = 5'h00;
	logic [7:0] seq = 8'h00;
	logic dmaOn = 1'b0;
	logic dmaTx, dmaRx;
	logic [7:0] dmaData;
	logic [1:0][7:0] fifoControl, txLevel, rxLevel;
	logic [1:0] rxReadyIrq, txEmptyIrq;
	logic txReqA, txReqB, rxReqA, rxReqB;
	logic [1:0][7:0] txHead, rxHead;
	logic [1:0] flowTrg, ovr;
	int errCount = 0;
	int nChecks = 0;
	int ovrCount = 0;
	int lvl;
	localparam logic [7:0] RX_TRG [4] = '{8'h08, 8'h10, 8'h18, 8'h1C};
	localparam logic [1:0] TX_CODE [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
	localparam int TX_TRG [4] = '{30, 24, 16, 8};
	always #5 sys_clk = ~sys_clk;
	uart_fifo_control_dma_ready uart_fifo_control_dma_ready_inst (
		.sys_clk(sys_clk), .rst(rst), .ctlWrite(ctlWrite),
		.ctlChannel(ctlChannel), .ctlData(ctlData), .extRxLevel(extRx),
		.extTxLevel(zero8), .flowThresholdLow(flowLo),
		.flowThresholdHigh(zero8), .txWrite({1'b0, act[0] | dmaTx}),
		.txWriteData({8'h00, dmaData}), .txTake({1'b0, act[1]}),
		.txTakeData(txHead), .rxLoad({1'b0, act[2]}),
		.rxLoadData({seq, seq}), .rxTimeout({1'b0, act[4]}),
		.rxRead({1'b0, act[3] | dmaRx}), .rxReadData(rxHead),
		.fifoControl(fifoControl), .txLevel(txLevel),
		.rxLevel(rxLevel), .rxReadyIrq(rxReadyIrq),
		.txEmptyIrq(txEmptyIrq), .flowTrigger(flowTrg),
		.rxOverrun(ovr),
		.txDmaRequestNChA(txReqA), .txDmaRequestNChB(txReqB),
		.rxDmaRequestNChA(rxReqA), .rxDmaRequestNChB(rxReqB));
	dma_ctrl_model dma_ctrl_model_inst (.sys_clk(sys_clk), .rst(rst),
		.active(dmaOn), .txReqN(txReqA), .rxReqN(rxReqA),
		.txPush(dmaTx), .rxPop(dmaRx), .txData(dmaData));
	// overrun stands one cycle only, so count it at every falling edge
	always @(negedge sys_clk) begin
		if (ovr[0] === 1'b1) begin
			ovrCount++;
		end
	end
	// ====
	// tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nChecks++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ctl(input logic ch, input logic [7:0] d);
		@(negedge sys_clk);
		ctlWrite = 1'b1;
		ctlChannel = ch;
		ctlData = d;
		@(negedge sys_clk);
		ctlWrite = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	// k: 0 host write, 1 take, 2 load, 3 host read, 4 rx time-out
	task automatic pulse(input int k, input int n);
		repeat (n) begin
			@(negedge sys_clk);
			act[k] = 1'b1;
			seq = seq + 8'h01;
			@(negedge sys_clk);
			act = 5'h00;
		end
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ====
	// tests
	initial begin
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(fifoControl[0], 8'h00);
		chk(fifoControl[1], 8'h00);
		chk(8'(txReqA), 8'h00);
		pulse(2, 2);
		chk(rxLevel[0], 8'h01);
		chk(rxHead[0], 8'h01);
		chk(8'(ovrCount), 8'h01);
		chk(8'(rxReqA), 8'h00);
		pulse(0, 1);
		chk(8'(txReqA), 8'h01);
		pulse(3, 1);
		chk(8'(rxReqA), 8'h01);
		pulse(1, 1);
		chk(8'(txReqA), 8'h00);
		$display("test mode0 done");
		foreach (RX_TRG[i]) begin
			ctl(1'b0, {2'(i), 6'b001011});
			pulse(2, int'(RX_TRG[i]) - 1);
			chk(8'(rxReqA), 8'h01);
			chk(8'(rxReadyIrq[0]), 8'h00);
			pulse(2, 1);
			chk(8'(rxReqA), 8'h00);
			chk(8'(rxReadyIrq[0]), 8'h01);
			chk(8'(flowTrg[0]), 8'h01);
			pulse(3, 1);
			chk(8'(rxReqA), 8'h00);
			chk(8'(rxReadyIrq[0]), 8'h00);
			chk(8'(flowTrg[0]), 8'h00);
		end
		pulse(2, 7);
		chk(rxLevel[0], 8'h20);
		chk(8'(ovrCount), 8'h03);
		ctl(1'b0, 8'h09);
		dmaOn = 1'b1;
		for (int k = 0; k < 1000; k++) begin
			if (rxLevel[0] === 8'h00 && txLevel[0] === 8'h20) begin
				break;
			end
			@(negedge sys_clk);
		end
		repeat (3) @(negedge sys_clk);
		dmaOn = 1'b0;
		chk(txLevel[0], 8'h20);
		chk(rxLevel[0], 8'h00);
		chk(txHead[0], 8'h01);
		chk(8'(txReqA), 8'h01);
		chk(8'(rxReqA), 8'h01);
		$display("test mode1 done");
		lvl = 32;
		foreach (TX_CODE[i]) begin
			ctl(1'b0, {2'b00, TX_CODE[i], 4'b1001});
			pulse(1, lvl - TX_TRG[i]);
			chk(8'(txEmptyIrq[0]), 8'h00);
			pulse(1, 1);
			chk(8'(txEmptyIrq[0]), 8'h01);
			chk(8'(txReqA), 8'h00);
			lvl = TX_TRG[i] - 1;
		end
		ctl(1'b0, 8'h0D);
		chk(txLevel[0], 8'h00);
		chk(fifoControl[0], 8'h09);
		pulse(2, 3);
		ctl(1'b0, 8'h0B);
		chk(rxLevel[0], 8'h00);
		pulse(2, 2);
		chk(8'(rxReqA), 8'h01);
		pulse(4, 1);
		chk(8'(rxReqA), 8'h00);
		pulse(3, 2);
		chk(8'(rxReqA), 8'h01);
		$display("test trigger done");
		extRx[0] = 8'h04;
		pulse(2, 3);
		chk(8'(rxReadyIrq[0]), 8'h00);
		pulse(2, 1);
		chk(8'(rxReadyIrq[0]), 8'h01);
		extRx[0] = 8'h00;
		repeat (2) @(negedge sys_clk);
		chk(8'(rxReadyIrq[0]), 8'h00);
		flowLo[0] = 8'h01;
		repeat (2) @(negedge sys_clk);
		chk(8'(rxReadyIrq[0]), 8'h01);
		flowLo[0] = 8'h00;
		ctl(1'b1, 8'h41);
		chk(fifoControl[1], 8'h41);
		chk(fifoControl[0], 8'h09);
		chk(8'(txReqB), 8'h00);
		chk(8'(rxReqB), 8'h01);
		ctl(1'b0, 8'h01);
		chk(8'(rxReqA), 8'h00);
		chk(8'(txReqA), 8'h00);
		pulse(0, 2);
		chk(8'(txReqA), 8'h01);
		$display("test extended done");
		wrapUp();
	end
	initial begin
		#200us;
		errCount++;
		wrapUp();
	end
endmodule
